// ---- core/hblw_latch.sv ----
// Transparent latch stage modelled as a clocked hold register
`timescale 1ns/10ps
module hblw_latch #(
  parameter int W = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic open_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] hold_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_reg <= '0;
    end else if (ce && open_en) begin
      hold_reg <= d;
    end
  end
  // Transparent while open, holds the last value while closed
  assign q = open_en ? d : hold_reg;
endmodule

// ---- core/hblw_pkg.sv ----
// Package with constants for the host bus latch and wait logic
package hblw_pkg;
  localparam int HBLW_ADDR_W = 20;
  localparam int HBLW_CFG_WAIT_BIT = 2;
  localparam int HBLW_CFG_W = 8;
  localparam logic [7:0] HBLW_CFG_RESET = 8'h00;
  // Crystal clocks with the ready line negated while waiting
  localparam int HBLW_WAIT_MIN_CLKS = 2;
  localparam int HBLW_WAIT_MAX_CLKS = 3;
  localparam logic [1:0] HBLW_WAIT_CLKS = 2'h2;
  // RAM window decode bits for the 16-bit memory indication
  localparam int HBLW_DEC_LSB = 11;
  localparam int HBLW_DEC_W = 9;
  typedef enum {HBLW_IDLE, HBLW_WAIT, HBLW_DONE} hblw_state_t;
endpackage

// ---- core/hblw_top.sv ----
// Host bus address latching and single wait state generation
`timescale 1ns/10ps
module hblw_top
  import hblw_pkg::*;
#(
  parameter int ADDR_W = HBLW_ADDR_W,
  parameter logic [HBLW_DEC_W-1:0] RAM_BASE = 9'h000
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire logic [ADDR_W-1:0] HOST_ADDR,
  input wire logic ADDR_LATCH_EN,
  input wire logic MEM_RD_N,
  input wire logic MEM_WR_N,
  input wire logic IO_RD_N,
  input wire logic IO_WR_N,
  input wire logic BOOT_ROM_ENABLE_N,
  input wire logic [HBLW_CFG_W-1:0] CFG_VALUE,
  output logic [ADDR_W-1:0] LATCHED_ADDR,
  output logic IOCHRDY,
  output logic MEM16_N
);
  logic [ADDR_W-1:0] stage1_q;
  logic [ADDR_W-1:0] stage2_q;
  logic strobe_any;
  logic strobe_mem;
  logic strobe_d_reg;
  logic mem_d_reg;
  logic cycle_start;
  logic mem_fall;
  logic wait_en;
  logic [1:0] wait_cnt_reg;
  logic rdy_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic mem16_reg;
  hblw_state_t state_reg;

  assign strobe_mem = !MEM_RD_N || !MEM_WR_N;
  // All cycle types share the one wait path
  assign strobe_any = strobe_mem || !IO_RD_N || !IO_WR_N;
  assign cycle_start = strobe_any && !strobe_d_reg;
  assign mem_fall = strobe_mem && !mem_d_reg;
  // Boot ROM enable is deliberately not part of this term
  assign wait_en = CFG_VALUE[HBLW_CFG_WAIT_BIT];

  // First stage follows the latch enable; held high it is always open
  hblw_latch #(.W(ADDR_W)) u_stage1 (
    .clk(CORE_CLK),
    .rst(RST),
    .ce(CLK_EN),
    .open_en(ADDR_LATCH_EN),
    .d(HOST_ADDR),
    .q(stage1_q)
  );

  // Second stage open until the memory strobe falls
  hblw_latch #(.W(ADDR_W)) u_stage2 (
    .clk(CORE_CLK),
    .rst(RST),
    .ce(CLK_EN),
    .open_en(!strobe_mem),
    .d(stage1_q),
    .q(stage2_q)
  );

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      strobe_d_reg <= 1'b0;
      mem_d_reg <= 1'b0;
    end else if (CLK_EN) begin
      strobe_d_reg <= strobe_any;
      mem_d_reg <= strobe_mem;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      addr_reg <= '0;
    end else if (CLK_EN && mem_fall) begin
      addr_reg <= stage1_q;
    end
  end
  assign LATCHED_ADDR = addr_reg;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mem16_reg <= 1'b1;
    end else if (CLK_EN) begin
      mem16_reg <= !(HOST_ADDR[HBLW_DEC_LSB +: HBLW_DEC_W] == RAM_BASE);
    end
  end
  assign MEM16_N = mem16_reg;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_reg <= HBLW_IDLE;
      wait_cnt_reg <= 2'h0;
      rdy_reg <= 1'b1;
    end else if (CLK_EN) begin
      case (state_reg)
        HBLW_IDLE: begin
          if (cycle_start && wait_en) begin
            state_reg <= HBLW_WAIT;
            wait_cnt_reg <= HBLW_WAIT_CLKS - 2'h1;
            rdy_reg <= 1'b0;
          end else begin
            rdy_reg <= 1'b1;
          end
        end
        HBLW_WAIT: begin
          if (wait_cnt_reg == 2'h0) begin
            state_reg <= HBLW_DONE;
            rdy_reg <= 1'b1;
          end else begin
            wait_cnt_reg <= wait_cnt_reg - 2'h1;
          end
        end
        HBLW_DONE: begin
          if (!strobe_any) begin
            state_reg <= HBLW_IDLE;
          end
        end
        default: begin
          state_reg <= HBLW_IDLE;
          rdy_reg <= 1'b1;
        end
      endcase
    end
  end
  assign IOCHRDY = rdy_reg;

  // Counts clocks seen low; holds the full length at the edge ready rises
  logic [2:0] low_cnt_reg;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      low_cnt_reg <= 3'h0;
    end else if (CLK_EN) begin
      low_cnt_reg <= rdy_reg ? 3'h0 : low_cnt_reg + 3'h1;
    end
  end

  sequence s_start_wait;
    CLK_EN && cycle_start && wait_en && state_reg == HBLW_IDLE;
  endsequence
  sequence s_low_two;
    !IOCHRDY [*2];
  endsequence
  // Idle, waits on, no strobe seen low at the previous edge
  sequence s_idle_armed;
    CLK_EN && state_reg == HBLW_IDLE && wait_en && !strobe_d_reg;
  endsequence

  a_wait_inserted: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_start_wait |=> s_low_two)
    else $error("wait state not inserted");
  a_wait_max_len: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    low_cnt_reg <= 3'(HBLW_WAIT_MAX_CLKS))
    else $error("ready held low too long");
  a_wait_min_len: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    CLK_EN && $rose(IOCHRDY) |-> low_cnt_reg >= 3'(HBLW_WAIT_MIN_CLKS))
    else $error("ready low too short");
  a_no_wait_off: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    CLK_EN && !wait_en && state_reg == HBLW_IDLE |=> IOCHRDY)
    else $error("ready negated with waits off");
  a_io_wait_same: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    CLK_EN && state_reg == HBLW_IDLE && wait_en && !IO_RD_N && !strobe_d_reg
    |=> !IOCHRDY)
    else $error("io cycle not waited");
  a_rom_no_effect: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_start_wait ##0 BOOT_ROM_ENABLE_N |=> !IOCHRDY)
    else $error("rom enable changed wait");
  a_addr_capture: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    CLK_EN && mem_fall |=> LATCHED_ADDR == $past(stage1_q))
    else $error("address not captured on strobe");
  a_latch_bypass: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    ADDR_LATCH_EN && !strobe_mem |-> stage2_q == HOST_ADDR)
    else $error("latches not transparent");
  a_addr_hold: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    CLK_EN && strobe_mem && mem_d_reg |=> $stable(LATCHED_ADDR))
    else $error("address changed in strobe");
  a_mem16_raw: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    CLK_EN |=> MEM16_N ==
      !($past(HOST_ADDR[HBLW_DEC_LSB +: HBLW_DEC_W]) == RAM_BASE))
    else $error("mem16 not from raw address");
  a_rom_low_same: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_start_wait ##0 !BOOT_ROM_ENABLE_N |=> !IOCHRDY)
    else $error("rom enable low changed wait");
  a_io_write_wait: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_idle_armed ##0 !IO_WR_N |=> !IOCHRDY)
    else $error("io write not waited");
  a_mem_write_wait: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_idle_armed ##0 !MEM_WR_N |=> !IOCHRDY)
    else $error("memory write not waited");
  a_done_ready: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    state_reg == HBLW_DONE |=> IOCHRDY)
    else $error("second wait state inserted");
  a_stage1_hold: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    !ADDR_LATCH_EN ##1 !ADDR_LATCH_EN |-> $stable(stage1_q))
    else $error("first stage moved while closed");
endmodule

// ---- test/hblw_host.sv ----
// Host bus master model running one strobe cycle per request
`timescale 1ns/10ps
module hblw_host (
  input wire logic clk,
  input wire logic go,
  input wire logic [1:0] kind,
  output logic mem_rd_n,
  output logic mem_wr_n,
  output logic io_rd_n,
  output logic io_wr_n
);
  logic [2:0] cnt_reg = 3'h0;
  logic [1:0] kind_reg = 2'h0;
  always_ff @(posedge clk) begin
    if (go) begin
      cnt_reg <= 3'h4;
      kind_reg <= kind;
    end else if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
    end
  end
  // Strobes rest high between cycles, as the bus pull-ups leave them
  always_comb begin
    mem_rd_n = !(cnt_reg != 3'h0 && kind_reg == 2'h0);
    mem_wr_n = !(cnt_reg != 3'h0 && kind_reg == 2'h1);
    io_rd_n = !(cnt_reg != 3'h0 && kind_reg == 2'h2);
    io_wr_n = !(cnt_reg != 3'h0 && kind_reg == 2'h3);
  end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the host bus latch and wait logic
`timescale 1ns/10ps
module tb_top;
  logic clk = 0, rst = 1, go = 0, ale = 1, boot_n = 1, ce = 1;
  logic [1:0] kind = 2'h0;
  logic [19:0] addr = 20'h0_0000;
  logic [7:0] cfg = 8'h00;
  logic mrd_n, mwr_n, ird_n, iwr_n, rdy, m16_n;
  logic [19:0] lat;
  int fails = 0, num_checks = 0;
  initial forever #25 clk = ~clk;
  hblw_host hblw_host_i (.clk(clk), .go(go), .kind(kind),
    .mem_rd_n(mrd_n), .mem_wr_n(mwr_n), .io_rd_n(ird_n), .io_wr_n(iwr_n));
  hblw_top hblw_top_i (.CORE_CLK(clk), .RST(rst), .CLK_EN(ce),
    .HOST_ADDR(addr), .ADDR_LATCH_EN(ale), .MEM_RD_N(mrd_n),
    .MEM_WR_N(mwr_n), .IO_RD_N(ird_n), .IO_WR_N(iwr_n),
    .BOOT_ROM_ENABLE_N(boot_n), .CFG_VALUE(cfg), .LATCHED_ADDR(lat),
    .IOCHRDY(rdy), .MEM16_N(m16_n));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // One host cycle; counts clocks with the ready line not high
  task automatic cyc(input logic [1:0] k, input logic [19:0] waits);
    int n;
    n = 0;
    @(posedge clk);
    kind <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (8) begin
      @(negedge clk);
      if (rdy !== 1'b1) n++;
    end
    chk(20'(n), waits);
  endtask
  task automatic t_nowait();
    cfg <= 8'h00;
    for (int k = 0; k < 4; k++) cyc(2'(k), 20'h0);
  endtask
  task automatic t_wait();
    @(posedge clk);
    cfg <= 8'h04;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      boot_n <= k[0];
      cyc(2'(k >> 1), 20'h2);
    end
  endtask
  task automatic t_latch();
    @(posedge clk);
    ale <= 1'b1;
    addr <= 20'hA_5A5A;
    cyc(2'h1, 20'h2);
    chk(lat, 20'hA_5A5A);
    @(posedge clk);
    addr <= 20'h3_C3C3;
    @(posedge clk);
    ale <= 1'b0;
    @(posedge clk);
    addr <= 20'h5_5555;
    cyc(2'h0, 20'h2);
    chk(lat, 20'h3_C3C3);
    @(posedge clk);
    ale <= 1'b1;
  endtask
  // Address moves one clock after the strobe falls; the capture must not
  task automatic t_hold();
    @(posedge clk);
    addr <= 20'h1_2345;
    kind <= 2'h1;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    addr <= 20'h6_789A;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(lat, 20'h1_2345);
  endtask
  // First stage closed on a non-RAM address; decode must follow raw lines
  task automatic t_decode();
    @(posedge clk);
    ale <= 1'b0;
    addr <= 20'h0_07FF;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_flag(m16_n, 1'b0);
    @(posedge clk);
    addr <= 20'h0_0800;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_flag(m16_n, 1'b1);
    @(posedge clk);
    ale <= 1'b1;
  endtask
  // Clock enable low freezes the decode flop
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    addr <= 20'h0_07FF;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_flag(m16_n, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_flag(m16_n, 1'b0);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_nowait();
    t_wait();
    t_latch();
    t_hold();
    t_decode();
    t_freeze();
    conclude();
  end
endmodule
